//--- rtl/host_memory_port.sv
// Host memory port: host handshake, read prefetch, write buffering and overlay control.
//
// Overview of operation
// - Acknowledge goes high soon after a read starts, showing the port busy.
// - Long read puts valid new data on the bus before acknowledge falls.
// - Read first shows previous word: two cycles, or one for second program half.
// - Program words move as two halves; data words in one access.
// - Bit 14 of overlay register at 0x3fe7 enables short-read-only; off at reset.
// - Overlay register is writable by the core and by the host through the port.
// - Short-read-only keeps previous word on the bus for the whole read.
// - Write accepted whether write pulse ends before or after acknowledge falls.
// - Host port pin functions replace memory bus functions only in port mode.
// - Mode pins are latched at reset release and kept afterwards.
`timescale 1ns/1ns
module host_memory_port
    import host_port_pkg::*;
(
    input  wire logic                            CLK_I,                 // Core clock.
    input  wire logic                            SYS_RST_I,             // Device reset.
    input  wire logic                            CE_I,                  // Clock enable.
    input  wire logic                            PORT_MODE_PIN_I,       // Port-mode strap.
    input  wire logic                            PORT_SELECT_N_I,       // Host select.
    input  wire logic                            PORT_READ_STROBE_N_I,  // Host read.
    input  wire logic                            PORT_WRITE_STROBE_N_I, // Host write.
    input  wire logic                            PORT_ADDRESS_LATCH_I,  // Host address latch.
    output logic                                 PORT_ACKNOWLEDGE_N_O,  // Port ready, low.
    input  wire logic [host_port_pkg::DATA_W-1:0] PORT_ADDR_DATA_BUS_I, // Shared pins in.
    output logic [host_port_pkg::DATA_W-1:0]     PORT_ADDR_DATA_BUS_O,  // Shared pins out.
    output logic                                 PORT_ADDR_DATA_BUS_OE_O, // Shared pins drive.
    input  wire logic [host_port_pkg::DATA_W-1:0] EXT_ADDR_I,           // Core memory address.
    input  wire logic                            EXT_ADDR_OE_I,         // Core address drive.
    output logic                                 PORT_MODE_O,           // Latched port mode.
    output logic                                 MEM_REQ_O,             // Memory request.
    output logic                                 MEM_WE_O,              // Memory write.
    output logic                                 MEM_DM_SEL_O,          // Data memory select.
    output logic [host_port_pkg::ADDR_W-1:0]     MEM_ADDR_O,            // Memory address.
    output logic [host_port_pkg::PM_W-1:0]       MEM_WDATA_O,           // Memory write data.
    input  wire logic [host_port_pkg::PM_W-1:0]  MEM_RDATA_I,           // Memory read data.
    input  wire logic                            MEM_ACK_I,             // Memory done pulse.
    input  wire logic                            CORE_OVL_WE_I,         // Core overlay write.
    input  wire logic [host_port_pkg::DATA_W-1:0] CORE_OVL_WDATA_I,     // Core overlay data.
    output logic [host_port_pkg::DATA_W-1:0]     OVL_REG_O              // Overlay register.
);
    import host_port_pkg::*;

    typedef struct packed {
        port_state_e       state;
        logic [1:0]        hold_cnt;
        logic              pm_half;
        logic              dm_sel;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] bus_out;
        logic              bus_oe;
        logic [DATA_W-1:0] prev_word;
        logic [PM_W-1:0]   rd_word;
        logic              rd_got;
        logic              rd_issued;
        logic [DATA_W-1:0] wr_hi;
        logic [DATA_W-1:0] wr_data;
        logic              mem_req;
        logic              mem_we;
        logic              mem_dm;
        logic [ADDR_W-1:0] mem_addr;
        logic [PM_W-1:0]   mem_wdata;
        logic [DATA_W-1:0] ovl;
    } port_s;

    port_s             st_reg;
    port_s             st_next;
    logic              sel_n;
    logic              rd_n;
    logic              wr_n;
    logic              addr_latch;
    logic              rd_active;
    logic              wr_active;
    logic              short_mode;
    logic              push_valid;
    logic              push_ready;
    logic [FIFO_W-1:0] push_data;
    logic              pop_valid;
    logic              pop_ready;
    logic [FIFO_W-1:0] pop_data;
    logic [DATA_W-1:0] wr_word;
    logic [DATA_W-1:0] new_word;

    port_pin_mux u_pin_mux (
        .clk_i      (CLK_I),
        .rst_i      (SYS_RST_I),
        .ce_i       (CE_I),
        .mode_pin_i (PORT_MODE_PIN_I),
        .sel_n_i    (PORT_SELECT_N_I),
        .rd_n_i     (PORT_READ_STROBE_N_I),
        .wr_n_i     (PORT_WRITE_STROBE_N_I),
        .latch_i    (PORT_ADDRESS_LATCH_I),
        .port_out_i (st_reg.bus_out),
        .port_oe_i  (st_reg.bus_oe),
        .ext_addr_i (EXT_ADDR_I),
        .ext_oe_i   (EXT_ADDR_OE_I),
        .mode_o     (PORT_MODE_O),
        .sel_n_o    (sel_n),
        .rd_n_o     (rd_n),
        .wr_n_o     (wr_n),
        .latch_o    (addr_latch),
        .pin_o      (PORT_ADDR_DATA_BUS_O),
        .pin_oe_o   (PORT_ADDR_DATA_BUS_OE_O)
    );

    port_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) u_wr_fifo (
        .clk_i       (CLK_I),
        .rst_i       (SYS_RST_I),
        .ce_i        (CE_I),
        .in_valid_i  (push_valid),
        .in_ready_o  (push_ready),
        .in_data_i   (push_data),
        .out_valid_o (pop_valid),
        .out_ready_i (pop_ready),
        .out_data_o  (pop_data)
    );

    assign rd_active  = !sel_n && !rd_n;
    assign wr_active  = !sel_n && !wr_n;
    assign short_mode = st_reg.ovl[OVL_SHORT_BIT];

    // Write data follows the bus while the pulse lasts, so an early end keeps the last value.
    assign wr_word = wr_active ? PORT_ADDR_DATA_BUS_I : st_reg.wr_data;
    assign new_word = st_reg.dm_sel ? st_reg.rd_word[DATA_W-1:0]
                                    : st_reg.rd_word[PM_W-1:PM_LOW_W];

    // A first program half waits in a holding register; only whole words enter the FIFO.
    assign push_valid = (st_reg.state == ST_WR_WAIT) && (st_reg.dm_sel || st_reg.pm_half);
    assign push_data  = st_reg.dm_sel
                        ? {st_reg.addr, 1'b1, {PM_LOW_W{1'b0}}, wr_word}
                        : {st_reg.addr, 1'b0, st_reg.wr_hi, wr_word[PM_LOW_W-1:0]};
    assign pop_ready  = !st_reg.mem_req;

    assign PORT_ACKNOWLEDGE_N_O = !(st_reg.state == ST_IDLE || st_reg.state == ST_RD_DONE ||
                                    st_reg.state == ST_WR_DONE);
    assign MEM_REQ_O    = st_reg.mem_req;
    assign MEM_WE_O     = st_reg.mem_we;
    assign MEM_DM_SEL_O = st_reg.mem_dm;
    assign MEM_ADDR_O   = st_reg.mem_addr;
    assign MEM_WDATA_O  = st_reg.mem_wdata;
    assign OVL_REG_O    = st_reg.ovl;

    always_comb begin
        st_next = st_reg;

        // Memory side: completion of the outstanding request.
        if (st_reg.mem_req && MEM_ACK_I) begin
            st_next.mem_req = 1'b0;
            if (!st_reg.mem_we) begin
                st_next.rd_word = MEM_RDATA_I;
                st_next.rd_got  = 1'b1;
            end
        end

        // Drain buffered writes; the overlay register is served here, not in memory.
        if (pop_valid && pop_ready) begin
            if (pop_data[PM_W] && pop_data[FIFO_W-1:PM_W+1] == OVL_ADDR) begin
                st_next.ovl = pop_data[DATA_W-1:0];
            end else begin
                st_next.mem_req   = 1'b1;
                st_next.mem_we    = 1'b1;
                st_next.mem_dm    = pop_data[PM_W];
                st_next.mem_addr  = pop_data[FIFO_W-1:PM_W+1];
                st_next.mem_wdata = pop_data[PM_W-1:0];
            end
        end
        if (CORE_OVL_WE_I) begin
            st_next.ovl = CORE_OVL_WDATA_I;
        end

        if (wr_active) begin
            st_next.wr_data = PORT_ADDR_DATA_BUS_I;
        end

        // Any read state drops the bus as soon as the access ends.
        if (!rd_active) begin
            st_next.bus_oe = 1'b0;
        end

        case (st_reg.state)
            ST_IDLE: begin
                if (addr_latch && !sel_n) begin
                    st_next.addr    = PORT_ADDR_DATA_BUS_I[ADDR_W-1:0];
                    st_next.dm_sel  = PORT_ADDR_DATA_BUS_I[ADDR_SPACE_BIT];
                    st_next.pm_half = 1'b0;
                end else if (rd_active) begin
                    st_next.state    = ST_RD_PREV;
                    st_next.bus_out  = st_reg.prev_word;
                    st_next.bus_oe   = 1'b1;
                    st_next.hold_cnt = (!st_reg.dm_sel && st_reg.pm_half) ? HOLD2_LOAD
                                                                        : HOLD1_LOAD;
                end else if (wr_active) begin
                    st_next.state = ST_WR_WAIT;
                end
            end
            ST_RD_PREV: begin
                if (st_reg.hold_cnt != 2'h0) begin
                    st_next.hold_cnt = st_reg.hold_cnt - 2'h1;
                end else if (!st_reg.dm_sel && st_reg.pm_half) begin
                    // Second program half comes from the word fetched by the first half.
                    st_next.prev_word = {{DATA_W-PM_LOW_W{1'b0}},
                                         st_reg.rd_word[PM_LOW_W-1:0]};
                    st_next.pm_half   = 1'b0;
                    st_next.addr      = st_reg.addr + 1'b1;
                    if (short_mode) begin
                        st_next.state = ST_RD_DONE;
                    end else begin
                        st_next.bus_out = {{DATA_W-PM_LOW_W{1'b0}},
                                           st_reg.rd_word[PM_LOW_W-1:0]};
                        st_next.state   = ST_RD_SETUP;
                    end
                end else begin
                    st_next.state     = ST_RD_FETCH;
                    st_next.rd_got    = 1'b0;
                    st_next.rd_issued = 1'b0;
                end
            end
            ST_RD_FETCH: begin
                // Reads wait for buffered writes so a read never overtakes a write.
                if (!st_reg.rd_issued && !st_reg.mem_req && !pop_valid) begin
                    st_next.rd_issued = 1'b1;
                    if (st_reg.dm_sel && st_reg.addr == OVL_ADDR) begin
                        st_next.rd_word = {{PM_LOW_W{1'b0}}, st_reg.ovl};
                        st_next.rd_got  = 1'b1;
                    end else begin
                        st_next.mem_req  = 1'b1;
                        st_next.mem_we   = 1'b0;
                        st_next.mem_dm   = st_reg.dm_sel;
                        st_next.mem_addr = st_reg.addr;
                    end
                end else if (st_reg.rd_got) begin
                    st_next.rd_got    = 1'b0;
                    st_next.prev_word = new_word;
                    if (st_reg.dm_sel) begin
                        st_next.addr = st_reg.addr + 1'b1;
                    end else begin
                        st_next.pm_half = 1'b1;
                    end
                    if (short_mode) begin
                        st_next.state = ST_RD_DONE;
                    end else begin
                        st_next.bus_out = new_word;
                        st_next.state   = ST_RD_SETUP;
                    end
                end
            end
            ST_RD_SETUP: begin
                st_next.state = ST_RD_DONE;
            end
            ST_RD_DONE: begin
                if (!rd_active) begin
                    st_next.state = ST_IDLE;
                end
            end
            ST_WR_WAIT: begin
                if (!st_reg.dm_sel && !st_reg.pm_half) begin
                    st_next.wr_hi   = wr_word;
                    st_next.pm_half = 1'b1;
                    st_next.state   = wr_active ? ST_WR_DONE : ST_IDLE;
                end else if (push_ready) begin
                    st_next.pm_half = 1'b0;
                    st_next.addr    = st_reg.addr + 1'b1;
                    st_next.state   = wr_active ? ST_WR_DONE : ST_IDLE;
                end
            end
            ST_WR_DONE: begin
                if (!wr_active) begin
                    st_next.state = ST_IDLE;
                end
            end
            default: begin
                st_next.state  = ST_IDLE;
                st_next.bus_oe = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            st_reg       <= '0;
            st_reg.state <= ST_IDLE;
            st_reg.ovl   <= OVL_RESET;
        end else if (CE_I) begin
            st_reg <= st_next;
        end
    end
endmodule : host_memory_port

//--- rtl/host_port_pkg.sv
// Shared constants, field positions and state codes of the host memory port.
package host_port_pkg;
    localparam int DATA_W         = 16;
    localparam int PM_W           = 24;
    localparam int ADDR_W         = 14;
    localparam int FIFO_DEPTH     = 32;
    localparam int FIFO_W         = ADDR_W + 1 + PM_W;
    localparam int PM_LOW_W       = PM_W - DATA_W;

    // Overlay control register and its short-read-only enable.
    localparam logic [ADDR_W-1:0] OVL_ADDR       = 14'h3fe7;
    localparam int                OVL_SHORT_BIT  = 14;
    localparam logic [DATA_W-1:0] OVL_RESET      = 16'h0000;

    // Address word layout: low bits are the word address, one bit selects data memory.
    localparam int ADDR_SPACE_BIT = 14;

    // Timing, expressed in core clock periods.
    localparam int CLK_PERIOD_NS  = 4;
    localparam int PREV_HOLD1_NS  = 2 * CLK_PERIOD_NS;
    localparam int PREV_HOLD2_NS  = CLK_PERIOD_NS;
    localparam int PREV_HOLD1_CYC = (PREV_HOLD1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PREV_HOLD2_CYC = (PREV_HOLD2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] HOLD1_LOAD = 2'(PREV_HOLD1_CYC - 1);
    localparam logic [1:0] HOLD2_LOAD = 2'(PREV_HOLD2_CYC - 1);

    typedef enum logic [6:0] {
        ST_IDLE     = 7'b0000001,
        ST_RD_PREV  = 7'b0000010,
        ST_RD_FETCH = 7'b0000100,
        ST_RD_SETUP = 7'b0001000,
        ST_RD_DONE  = 7'b0010000,
        ST_WR_WAIT  = 7'b0100000,
        ST_WR_DONE  = 7'b1000000
    } port_state_e;
endpackage : host_port_pkg

//--- rtl/port_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ns
module port_fifo #(
    parameter int WIDTH = 39,
    parameter int DEPTH = 32
) (
    input  wire logic             clk_i,      // Core clock.
    input  wire logic             rst_i,      // Asynchronous reset, active high.
    input  wire logic             ce_i,       // Clock enable.
    input  wire logic             in_valid_i, // Entry offered.
    output logic                  in_ready_o, // Room for an entry.
    input  wire logic [WIDTH-1:0] in_data_i,  // Entry to store.
    output logic                  out_valid_o,// Entry available.
    input  wire logic             out_ready_i,// Sink takes the entry.
    output logic [WIDTH-1:0]      out_data_o  // Oldest entry.
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW:0]                 wr_ptr;
        logic [PW:0]                 rd_ptr;
    } fifo_s;

    fifo_s st_reg;
    fifo_s st_next;
    logic  full;
    logic  empty;

    assign empty       = st_reg.wr_ptr == st_reg.rd_ptr;
    assign full        = (st_reg.wr_ptr[PW] != st_reg.rd_ptr[PW]) &&
                         (st_reg.wr_ptr[PW-1:0] == st_reg.rd_ptr[PW-1:0]);
    assign in_ready_o  = !full;
    assign out_valid_o = !empty;
    assign out_data_o  = st_reg.mem[st_reg.rd_ptr[PW-1:0]];

    always_comb begin
        st_next = st_reg;
        if (in_valid_i && !full) begin
            st_next.mem[st_reg.wr_ptr[PW-1:0]] = in_data_i;
            st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
        end
        if (out_ready_i && !empty) begin
            st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_reg <= '0;
        end else if (ce_i) begin
            st_reg <= st_next;
        end
    end
endmodule : port_fifo

//--- rtl/port_pin_mux.sv
// Mode strap capture and sharing of pins between host port and memory bus.
`timescale 1ns/1ns
module port_pin_mux (
    input  wire logic        clk_i,        // Core clock.
    input  wire logic        rst_i,        // Asynchronous reset, active high.
    input  wire logic        ce_i,         // Clock enable.
    input  wire logic        mode_pin_i,   // Port-mode strap pin.
    input  wire logic        sel_n_i,      // Select pin.
    input  wire logic        rd_n_i,       // Read strobe pin.
    input  wire logic        wr_n_i,       // Write strobe pin.
    input  wire logic        latch_i,      // Address latch pin.
    input  wire logic [15:0] port_out_i,   // Port bus value.
    input  wire logic        port_oe_i,    // Port bus drive.
    input  wire logic [15:0] ext_addr_i,   // Memory bus address.
    input  wire logic        ext_oe_i,     // Memory bus drive.
    output logic             mode_o,       // Latched port mode.
    output logic             sel_n_o,      // Select seen by the port.
    output logic             rd_n_o,       // Read strobe seen by the port.
    output logic             wr_n_o,       // Write strobe seen by the port.
    output logic             latch_o,      // Address latch seen by the port.
    output logic [15:0]      pin_o,        // Shared pin value.
    output logic             pin_oe_o      // Shared pin drive.
);
    typedef struct packed {
        logic taken;
        logic mode;
    } strap_s;

    strap_s st_reg;
    strap_s st_next;

    // The strap is caught on the first enabled edge after reset release and kept.
    always_comb begin
        st_next = st_reg;
        if (!st_reg.taken) begin
            st_next.taken = 1'b1;
            st_next.mode  = mode_pin_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_reg <= '0;
        end else if (ce_i) begin
            st_reg <= st_next;
        end
    end

    assign mode_o   = st_reg.mode;
    assign sel_n_o  = st_reg.mode ? sel_n_i : 1'b1;
    assign rd_n_o   = st_reg.mode ? rd_n_i : 1'b1;
    assign wr_n_o   = st_reg.mode ? wr_n_i : 1'b1;
    assign latch_o  = st_reg.mode && latch_i;
    assign pin_o    = st_reg.mode ? port_out_i : ext_addr_i;
    assign pin_oe_o = st_reg.mode ? port_oe_i : ext_oe_i;
endmodule : port_pin_mux

//--- tb/host_memory_port_checker.sv
// Concurrent checks on the host memory port.
`timescale 1ns/1ns
module host_memory_port_checker
    import host_port_pkg::*;
(
    input wire logic              CLK_I,                   // Clock.
    input wire logic              SYS_RST_I,               // Reset.
    input wire logic              CE_I,                    // Enable.
    input wire logic              PORT_SELECT_N_I,         // Select.
    input wire logic              PORT_READ_STROBE_N_I,    // Read.
    input wire logic              PORT_WRITE_STROBE_N_I,   // Write.
    input wire logic              PORT_ADDRESS_LATCH_I,    // Latch.
    input wire logic              PORT_ACKNOWLEDGE_N_O,    // Acknowledge.
    input wire logic [DATA_W-1:0] PORT_ADDR_DATA_BUS_O,    // Bus out.
    input wire logic              PORT_ADDR_DATA_BUS_OE_O, // Bus drive.
    input wire logic [DATA_W-1:0] EXT_ADDR_I,              // Core address.
    input wire logic              EXT_ADDR_OE_I,           // Core drive.
    input wire logic              PORT_MODE_O,             // Mode.
    input wire logic              CORE_OVL_WE_I,           // Core write.
    input wire logic [DATA_W-1:0] CORE_OVL_WDATA_I,        // Core data.
    input wire logic [DATA_W-1:0] OVL_REG_O                // Overlay.
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);

    a_read_start: assert property (PORT_MODE_O && !PORT_ACKNOWLEDGE_N_O && !PORT_SELECT_N_I
        && $fell(PORT_READ_STROBE_N_I) |=> PORT_ACKNOWLEDGE_N_O && PORT_ADDR_DATA_BUS_OE_O)
        else $error("read start not answered");
    a_write_start: assert property (PORT_MODE_O && !PORT_ACKNOWLEDGE_N_O && !PORT_SELECT_N_I
        && $fell(PORT_WRITE_STROBE_N_I) |=> PORT_ACKNOWLEDGE_N_O)
        else $error("write start not answered");
    a_data_before_ack: assert property ($fell(PORT_ACKNOWLEDGE_N_O) && PORT_MODE_O
        && !PORT_READ_STROBE_N_I && !PORT_SELECT_N_I && !OVL_REG_O[OVL_SHORT_BIT]
        |-> PORT_ADDR_DATA_BUS_OE_O && $stable(PORT_ADDR_DATA_BUS_O))
        else $error("read data not ready at acknowledge");
    a_short_hold: assert property (PORT_MODE_O && OVL_REG_O[OVL_SHORT_BIT] && !PORT_SELECT_N_I
        && !PORT_READ_STROBE_N_I && PORT_ADDR_DATA_BUS_OE_O
        |=> PORT_SELECT_N_I || PORT_READ_STROBE_N_I || $stable(PORT_ADDR_DATA_BUS_O))
        else $error("short read word changed");
    a_bus_release: assert property (PORT_MODE_O && $rose(PORT_READ_STROBE_N_I)
        |-> ##[1:2] !PORT_ADDR_DATA_BUS_OE_O)
        else $error("bus not released after read");
    a_ack_idle: assert property (PORT_MODE_O && !PORT_ACKNOWLEDGE_N_O && !PORT_ADDRESS_LATCH_I
        && (PORT_SELECT_N_I || (PORT_READ_STROBE_N_I && PORT_WRITE_STROBE_N_I))
        |=> !PORT_ACKNOWLEDGE_N_O)
        else $error("acknowledge rose without access");
    a_mode_kept: assert property (!$past(SYS_RST_I) |=> $stable(PORT_MODE_O))
        else $error("latched mode changed");
    a_pin_share: assert property (!PORT_MODE_O |-> PORT_ADDR_DATA_BUS_O == EXT_ADDR_I
        && PORT_ADDR_DATA_BUS_OE_O == EXT_ADDR_OE_I)
        else $error("shared pins not on memory bus");
    a_ovl_reset: assert property ($fell(SYS_RST_I) |-> OVL_REG_O == OVL_RESET)
        else $error("overlay not cleared by reset");
    a_core_ovl: assert property (CE_I && CORE_OVL_WE_I |=> OVL_REG_O == $past(CORE_OVL_WDATA_I))
        else $error("core overlay write lost");
endmodule : host_memory_port_checker

bind host_memory_port host_memory_port_checker u_checker (.*);

//--- tb/host_model.sv
// Host model: drives select, strobes, address latch and the shared bus of the port.
`timescale 1ns/1ns
module host_model (
    input  wire logic        clk_i,          // Core clock.
    input  wire logic        ack_n_i,        // Port acknowledge.
    input  wire logic [15:0] bus_i,          // Resolved shared bus.
    output logic             sel_n_o = 1'b1, // Select.
    output logic             rd_n_o  = 1'b1, // Read strobe.
    output logic             wr_n_o  = 1'b1, // Write strobe.
    output logic             latch_o = 1'b0, // Address latch.
    output logic [15:0]      drv_o   = '0    // Host bus value.
);
    // Op 0 latches, 1 writes, 2 reads; early ends a write before acknowledge.
    task automatic xfer(input logic [1:0] op, input logic [15:0] wd, input logic early,
                        output logic [15:0] rd, output logic tmo);
        int n;
        n = 0;
        while (ack_n_i !== 1'b0 && n < 400) begin
            @(negedge clk_i);
            n++;
        end
        sel_n_o = 1'b0;
        latch_o = (op == 2'd0);
        wr_n_o  = (op != 2'd1);
        rd_n_o  = (op != 2'd2);
        drv_o   = (op == 2'd2) ? ~drv_o : wd;
        @(negedge clk_i);
        if (op != 2'd0 && !early) begin
            @(negedge clk_i);
            while (ack_n_i !== 1'b0 && n < 400) begin
                @(negedge clk_i);
                n++;
            end
        end
        rd = bus_i;
        sel_n_o = 1'b1;
        latch_o = 1'b0;
        wr_n_o  = 1'b1;
        rd_n_o  = 1'b1;
        @(negedge clk_i);
        tmo = (n >= 400);
    endtask : xfer
endmodule : host_model

//--- tb/host_memory_port_tb_top.sv
// Self-checking bench of the host memory port.
`timescale 1ns/1ns
module host_memory_port_tb_top;
    import host_port_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, mode_pin = 1'b1, core_we = 1'b0, ext_oe = 1'b0;
    logic        mem_ack = 1'b0, stall = 1'b0, tmo;
    logic        sel_n, rd_n, wr_n, latch, ack_n, oe, mode, req, we, dm;
    logic [15:0] core_wd = '0, ext_addr = '0, hdrv, bus_o, bus, ovl, rdv;
    logic [13:0] maddr;
    logic [23:0] mem_rd = '0, wdat, w;
    logic [23:0] mem [0:32767];
    logic [23:0] dmw [0:39];
    int          err_total = 0, check_count = 0, i;
    int          seed = 32'h2e757cc2;

    assign bus = oe ? bus_o : hdrv;
    always #2 clk = ~clk;
    always @(posedge clk) begin
        mem_ack <= req && !mem_ack && !stall && (($random(seed) & 1) == 0);
        mem_rd  <= mem[{dm, maddr}];
        if (req && we) begin
            mem[{dm, maddr}] <= wdat;
        end
    end

    host_memory_port u_dut (
        .CLK_I(clk), .SYS_RST_I(rst), .CE_I(1'b1), .PORT_MODE_PIN_I(mode_pin),
        .PORT_SELECT_N_I(sel_n), .PORT_READ_STROBE_N_I(rd_n), .PORT_WRITE_STROBE_N_I(wr_n),
        .PORT_ADDRESS_LATCH_I(latch), .PORT_ACKNOWLEDGE_N_O(ack_n),
        .PORT_ADDR_DATA_BUS_I(bus), .PORT_ADDR_DATA_BUS_O(bus_o),
        .PORT_ADDR_DATA_BUS_OE_O(oe), .EXT_ADDR_I(ext_addr), .EXT_ADDR_OE_I(ext_oe),
        .PORT_MODE_O(mode), .MEM_REQ_O(req), .MEM_WE_O(we), .MEM_DM_SEL_O(dm),
        .MEM_ADDR_O(maddr), .MEM_WDATA_O(wdat), .MEM_RDATA_I(mem_rd), .MEM_ACK_I(mem_ack),
        .CORE_OVL_WE_I(core_we), .CORE_OVL_WDATA_I(core_wd), .OVL_REG_O(ovl));
    host_model u_host (.clk_i(clk), .ack_n_i(ack_n), .bus_i(bus), .sel_n_o(sel_n),
        .rd_n_o(rd_n), .wr_n_o(wr_n), .latch_o(latch), .drv_o(hdrv));

    function automatic logic [15:0] pm_half(input logic [23:0] x, input logic second);
        return second ? {8'h00, x[7:0]} : x[23:8];
    endfunction : pm_half
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up();
        if (err_total == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up
    task automatic go(input logic [1:0] op, input logic [15:0] wd, input logic early);
        u_host.xfer(op, wd, early, rdv, tmo);
        check(tmo, 1'b0);
    endtask : go
    task automatic do_reset(input logic m);
        rst = 1'b1;
        mode_pin = m;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
    endtask : do_reset

    initial begin
        do_reset(1'b1);
        check(ack_n, 1'b0);
        check(ovl, OVL_RESET);
        mode_pin = 1'b0;
        stall = 1'b1;
        go(2'd0, 16'h4010, 1'b0);
        fork
            for (i = 0; i < 40; i++) begin
                dmw[i] = 24'($random(seed));
                go(2'd1, dmw[i][15:0], i[0]);
            end
            begin
                repeat (300) @(negedge clk);
                check(ack_n, 1'b1);
                stall = 1'b0;
            end
        join
        check(mode, 1'b1);
        go(2'd0, 16'h4010, 1'b0);
        for (i = 0; i < 40; i++) begin
            go(2'd2, 16'h0000, 1'b0);
            check(rdv, dmw[i][15:0]);
        end
        w = 24'($random(seed));
        go(2'd0, 16'h0020, 1'b0);
        go(2'd1, pm_half(w, 1'b0), 1'b0);
        go(2'd1, pm_half(w, 1'b1), 1'b1);
        go(2'd0, 16'h0020, 1'b0);
        go(2'd2, 16'h0000, 1'b0);
        check(rdv, pm_half(w, 1'b0));
        go(2'd2, 16'h0000, 1'b0);
        check(rdv, pm_half(w, 1'b1));
        go(2'd0, {2'b01, OVL_ADDR}, 1'b0);
        go(2'd1, 16'h4000, 1'b0);
        repeat (20) @(negedge clk);
        check(ovl, 16'h4000);
        go(2'd0, 16'h4010, 1'b0);
        go(2'd2, 16'h0000, 1'b0);
        check(rdv, pm_half(w, 1'b1));
        go(2'd2, 16'h0000, 1'b0);
        check(rdv, dmw[0][15:0]);
        core_we = 1'b1;
        core_wd = 16'($random(seed));
        @(negedge clk);
        core_we = 1'b0;
        check(ovl, core_wd);
        do_reset(1'b0);
        ext_addr = 16'($random(seed));
        ext_oe = 1'b1;
        @(negedge clk);
        check(mode, 1'b0);
        check(bus_o, ext_addr);
        check(oe, ext_oe);
        wrap_up();
    end

    initial begin
        repeat (20000) @(negedge clk);
        err_total++;
        wrap_up();
    end
endmodule : host_memory_port_tb_top
